/* fsop_pkg.sv */
// Package: constants and carrier types for the framed serial output port
package fsop_pkg;
  // Core clock and serial clock limits
  localparam int unsigned CORE_CLK_KHZ = 200000;
  localparam int unsigned MASTER_SCLK_MAX_KHZ = 33500;
  localparam int unsigned MIN_HALF_CYC =
    (CORE_CLK_KHZ + 2 * MASTER_SCLK_MAX_KHZ - 1) / (2 * MASTER_SCLK_MAX_KHZ);
  localparam logic [3:0] MIN_HALF = 4'(MIN_HALF_CYC);
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  // Control register field positions
  localparam int CTRL_MASTER_BIT = 0;
  localparam int CTRL_WL_LSB = 1;
  localparam int CTRL_APPEND_BIT = 3;
  localparam int CTRL_DIV_BIT = 4;
  localparam int CTRL_SDIV_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Status register field positions
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_RDPEND_BIT = 1;
  localparam int STAT_FCNT_LSB = 8;
  // Word length codes
  localparam logic [1:0] WL_16 = 2'h0;
  localparam logic [1:0] WL_24 = 2'h1;
  localparam logic [1:0] WL_32 = 2'h2;
  // Command word layout (first 16 bits shifted in)
  localparam int CMD_READ_BIT = 15;
  localparam int CMD_WRITE_BIT = 14;
  localparam int CMD_ADDR_LSB = 8;
  localparam logic [4:0] CMD_LAST_BIT = 5'h0f;
  localparam int SAMPLE_W = 23;

  typedef struct packed {
    logic [SAMPLE_W-1:0] a_i;
    logic [SAMPLE_W-1:0] a_q;
    logic [SAMPLE_W-1:0] b_i;
    logic [SAMPLE_W-1:0] b_q;
  } fsop_iq_s;

  typedef struct packed {
    logic read;
    logic write;
    logic [2:0] addr;
    logic [7:0] wdata;
  } fsop_cmd_s;

  typedef struct packed {
    logic [3:0] sdiv;
    logic diversity;
    logic append;
    logic [1:0] wl;
    logic master;
  } fsop_cfg_s;

  typedef enum logic [1:0] {
    FSOP_IDLE = 2'b00,
    FSOP_SYNC = 2'b01,
    FSOP_SHIFT = 2'b10
  } fsop_state_e;
endpackage

/* fsop_clkdiv.sv */
// Serial clock divider: makes the master serial clock and its edge enables
`timescale 1ns/1ps
module fsop_clkdiv (
  input wire logic ref_clk, // Core clock
  input wire logic arst_n, // Async reset, active low
  input wire logic run, // Divider runs while high
  input wire logic [3:0] divider, // Serial clock divider value
  output logic sclk_q, // Divided serial clock
  output logic rise_q, // Pulse: sclk_q just rose
  output logic fall_q // Pulse: sclk_q just fell
);
  import fsop_pkg::*;

  logic [3:0] half_t;
  logic [3:0] cnt_q;

  // Zero means divide by two; clamped so the pin never beats the master limit
  always_comb begin
    half_t = (divider == 4'h0) ? 4'h1 : divider;
    if (half_t < MIN_HALF) begin
      half_t = MIN_HALF;
    end
  end

  // Half-period counter; each wrap flips the clock
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 4'h0;
      sclk_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else if (!run) begin
      cnt_q <= 4'h0;
      sclk_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else if (cnt_q == half_t - 4'h1) begin
      cnt_q <= 4'h0;
      sclk_q <= ~sclk_q;
      rise_q <= ~sclk_q;
      fall_q <= sclk_q;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
  end
endmodule

/* fsop_port.sv */
// Framed serial output port with serial command intake and Avalon-MM control
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
// Functional notes
// - Master drives serial clock and frame sync; slave takes both in.
// - Inputs sampled on falling serial edge, outputs changed on rising edge.
// - Sampled frame sync starts the slot at the next rising edge.
// - Master pulses frame sync one serial cycle, transfer follows immediately.
// - Master serial clock never exceeds 33.5 MHz or half the core clock.
// - Frame starts with A I msb; ends with A Q, B Q or the read-back word.
// - Serial data output is released outside the own slot.
// - Frame end is high in the slot's last serial cycle.
// - A chained slave starts on frame end with no idle gap.
// - Word length code picks 16, 24 or 32 bit words.
// - Words go msb first, left justified, padding at the end.
// - 24 and 32 bit words carry 23-bit samples.
// - Without append a frame holds two or four data words.
// - Append adds a read-back word, zero when nothing was read.
// - A read request forces the read-back word even without append; here a read in the last 16-bit data word comes too late to add it.
// - Master divides core clock by twice the divider, never by less than six.
// - In slave mode the divider is ignored.
// - Frames are spaced by zero or at least two core cycles.
// - Command: read and write flags, three-bit select, data in low byte.
// - Reads per frame limited to two, three or four by word length.
// - Read bytes packed into read-back word in order, first at the top.
module fsop_port (
  input wire logic ref_clk, // Core clock, 200 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic [7:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read request
  input wire logic avs_write, // Avalon write request
  input wire logic [31:0] avs_writedata, // Avalon write data
  input wire logic [3:0] avs_byteenable, // Avalon byte enables
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon wait request
  input wire logic iq_valid, // Pulse: new I/Q set ready
  input wire fsop_pkg::fsop_iq_s iq_data, // I/Q samples
  output fsop_pkg::fsop_cmd_s cmd_q, // Decoded serial command
  output logic cmd_valid_q, // Pulse: command valid
  input wire logic rd_ack, // Pulse: read byte returned
  input wire logic [7:0] rd_data, // Read byte from register file
  input wire logic sclk_i, // Serial clock pin input
  output logic sclk_o, // Serial clock pin output
  output logic sclk_oe, // Serial clock drive enable
  input wire logic fs_i, // Frame sync pin input
  output logic fs_o, // Frame sync pin output
  output logic fs_oe, // Frame sync drive enable
  input wire logic sdi_i, // Serial command input
  output logic sdo_o, // Serial data output
  output logic sdo_oe, // Serial data drive enable
  output logic frame_end_o // Frame end output
);
  import fsop_pkg::*;

  fsop_cfg_s cfg_q;
  fsop_state_e state_q;
  fsop_iq_s iq_q;
  fsop_iq_s frame_q;
  logic [31:0] ctrl_t;
  logic [31:0] rd_word_q;
  logic [2:0] rd_cnt_q;
  logic [2:0] ack_cnt_q;
  logic [2:0] word_idx_q;
  logic [4:0] bit_idx_q;
  logic [4:0] rx_cnt_q;
  logic [2:0] rx_word_q;
  logic [14:0] rx_sr_q;
  logic [7:0] fcnt_q;
  logic pend_q;
  logic fs_seen_q;
  logic last_q;
  logic sclk_prev_q;
  logic div_sclk;
  logic div_rise;
  logic div_fall;
  logic rise_en;
  logic fall_en;
  logic fs_smp;
  logic word_end;
  logic frame_last;
  logic has_rd_word;
  logic [2:0] data_words;
  logic [31:0] cur_word;
  logic [31:0] first_word;
  logic [15:0] cmd_word;

  // Last bit index of a serial word for a length code
  function automatic logic [4:0] wl_last(input logic [1:0] wl);
    case (wl)
      WL_16: wl_last = 5'd15;
      WL_24: wl_last = 5'd23;
      WL_32: wl_last = 5'd31;
      default: wl_last = 5'd15;
    endcase
  endfunction

  // Read limit per frame for a length code
  function automatic logic [2:0] max_reads(input logic [1:0] wl);
    case (wl)
      WL_16: max_reads = 3'd2;
      WL_24: max_reads = 3'd3;
      WL_32: max_reads = 3'd4;
      default: max_reads = 3'd2;
    endcase
  endfunction

  // Left-justified word image of a sample; 16-bit words keep the top bits
  function automatic logic [31:0] sample_word(input logic [SAMPLE_W-1:0] s,
                                              input logic [1:0] wl);
    if (wl == WL_16) begin
      sample_word = {s[SAMPLE_W-1:SAMPLE_W-16], 16'h0000};
    end else begin
      sample_word = {s, 9'h000};
    end
  endfunction

  // Serial clock master divider; idle in slave mode so the divider is unused
  fsop_clkdiv u_div (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .run(cfg_q.master),
    .divider(cfg_q.sdiv),
    .sclk_q(div_sclk),
    .rise_q(div_rise),
    .fall_q(div_fall)
  );

  // Edge enables come from the divider or from the external clock pin
  always_comb begin
    if (cfg_q.master) begin
      rise_en = div_rise;
      fall_en = div_fall;
      fs_smp = fs_o;
    end else begin
      rise_en = sclk_i & ~sclk_prev_q;
      fall_en = ~sclk_i & sclk_prev_q;
      fs_smp = fs_i;
    end
  end

  // Frame layout: data words, optional read-back word, current word image
  always_comb begin
    data_words = cfg_q.diversity ? 3'd4 : 3'd2;
    has_rd_word = cfg_q.append | (rd_cnt_q != 3'd0);
    word_end = (bit_idx_q == wl_last(cfg_q.wl));
    if (has_rd_word) begin
      frame_last = word_end && (word_idx_q == data_words);
    end else begin
      frame_last = word_end && (word_idx_q == data_words - 3'd1);
    end
    case (word_idx_q)
      3'd0: cur_word = sample_word(frame_q.a_i, cfg_q.wl);
      3'd1: cur_word = sample_word(frame_q.a_q, cfg_q.wl);
      3'd2: cur_word = cfg_q.diversity ? sample_word(frame_q.b_i, cfg_q.wl) : rd_word_q;
      3'd3: cur_word = sample_word(frame_q.b_q, cfg_q.wl);
      default: cur_word = rd_word_q;
    endcase
    cmd_word = {rx_sr_q, sdi_i};
    first_word = sample_word(iq_q.a_i, cfg_q.wl);
  end

  // Pin direction follows the master select
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_o <= 1'b0;
      sclk_oe <= 1'b0;
      fs_oe <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_o <= div_sclk;
      sclk_oe <= cfg_q.master;
      fs_oe <= cfg_q.master;
      sclk_prev_q <= sclk_i;
    end
  end

  // Holding register for the newest sample set; master waits for it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      iq_q <= '0;
      pend_q <= 1'b0;
    end else begin
      if (iq_valid) begin
        iq_q <= iq_data;
      end
      if (iq_valid) begin
        pend_q <= 1'b1;
      end else if (rise_en && fs_seen_q) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Frame sync is sampled on the falling serial edge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fs_seen_q <= 1'b0;
    end else if (fall_en) begin
      fs_seen_q <= fs_smp;
    end else if (rise_en) begin
      fs_seen_q <= 1'b0;
    end
  end

  // Transmit sequencer; all pin changes happen on rising enables
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= FSOP_IDLE;
      fs_o <= 1'b0;
      sdo_o <= 1'b0;
      sdo_oe <= 1'b0;
      frame_end_o <= 1'b0;
      last_q <= 1'b0;
      word_idx_q <= 3'd0;
      bit_idx_q <= 5'd0;
      frame_q <= '0;
      fcnt_q <= 8'h00;
    end else if (rise_en) begin
      fs_o <= 1'b0;
      if (fs_seen_q) begin
        // Start right away; a back-to-back frame leaves no idle cycle
        state_q <= FSOP_SHIFT;
        frame_q <= iq_q;
        sdo_o <= first_word[31];
        sdo_oe <= 1'b1;
        word_idx_q <= 3'd0;
        bit_idx_q <= 5'd1;
        frame_end_o <= 1'b0;
        last_q <= 1'b0;
        fcnt_q <= fcnt_q + 8'h01;
      end else if (state_q == FSOP_SHIFT && !last_q) begin
        sdo_o <= cur_word[5'd31 - bit_idx_q];
        frame_end_o <= frame_last;
        last_q <= frame_last;
        if (word_end) begin
          word_idx_q <= word_idx_q + 3'd1;
          bit_idx_q <= 5'd0;
        end else begin
          bit_idx_q <= bit_idx_q + 5'd1;
        end
      end else if (state_q == FSOP_IDLE && cfg_q.master && pend_q) begin
        // One serial cycle of sync; gaps are whole serial cycles, never one core cycle
        fs_o <= 1'b1;
        state_q <= FSOP_SYNC;
      end else if (state_q == FSOP_SHIFT) begin
        // Slot over: release the shared data line
        state_q <= FSOP_IDLE;
        sdo_oe <= 1'b0;
        sdo_o <= 1'b0;
        frame_end_o <= 1'b0;
        last_q <= 1'b0;
      end
    end
  end

  // Command intake: a word's first 16 bits are gathered on falling edges
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_sr_q <= 15'h0000;
      rx_cnt_q <= 5'd0;
      rx_word_q <= 3'd0;
      cmd_q <= '0;
      cmd_valid_q <= 1'b0;
      rd_cnt_q <= 3'd0;
    end else begin
      cmd_valid_q <= 1'b0;
      if (rise_en && fs_seen_q) begin
        rx_cnt_q <= 5'd0;
        rx_word_q <= 3'd0;
        rd_cnt_q <= 3'd0;
      end else if (fall_en && state_q == FSOP_SHIFT && sdo_oe) begin
        rx_sr_q <= {rx_sr_q[13:0], sdi_i};
        // Own word count: the output index has already moved on at a 16-bit word's last bit
        if (rx_cnt_q == wl_last(cfg_q.wl)) begin
          rx_cnt_q <= 5'd0;
          rx_word_q <= rx_word_q + 3'd1;
        end else begin
          rx_cnt_q <= rx_cnt_q + 5'd1;
        end
        // Commands in the read-back word are not decoded
        if (rx_cnt_q == CMD_LAST_BIT && rx_word_q < data_words) begin
          if (cmd_word[CMD_READ_BIT] && !cmd_word[CMD_WRITE_BIT]) begin
            if (rd_cnt_q < max_reads(cfg_q.wl)) begin
              rd_cnt_q <= rd_cnt_q + 3'd1;
              cmd_valid_q <= 1'b1;
            end
          end else if (cmd_word[CMD_WRITE_BIT] && !cmd_word[CMD_READ_BIT]) begin
            cmd_valid_q <= 1'b1;
          end
          cmd_q.read <= cmd_word[CMD_READ_BIT];
          cmd_q.write <= cmd_word[CMD_WRITE_BIT];
          cmd_q.addr <= cmd_word[CMD_ADDR_LSB +: 3];
          cmd_q.wdata <= cmd_word[7:0];
        end
      end
    end
  end

  // Read-back word: bytes land in request order from the top byte down
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_word_q <= 32'h0000_0000;
      ack_cnt_q <= 3'd0;
    end else if (rise_en && fs_seen_q) begin
      rd_word_q <= 32'h0000_0000;
      ack_cnt_q <= 3'd0;
    end else if (rd_ack && ack_cnt_q < 3'd4) begin
      rd_word_q[5'd24 - {ack_cnt_q[1:0], 3'b000} +: 8] <= rd_data;
      ack_cnt_q <= ack_cnt_q + 3'd1;
    end
  end

  // Control register image for readback
  always_comb begin
    ctrl_t = 32'h0000_0000;
    ctrl_t[CTRL_MASTER_BIT] = cfg_q.master;
    ctrl_t[CTRL_WL_LSB +: 2] = cfg_q.wl;
    ctrl_t[CTRL_APPEND_BIT] = cfg_q.append;
    ctrl_t[CTRL_DIV_BIT] = cfg_q.diversity;
    ctrl_t[CTRL_SDIV_LSB +: 4] = cfg_q.sdiv;
  end

  // Avalon slave: one wait cycle, then the access completes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      cfg_q <= fsop_cfg_s'(CTRL_RESET[8:0]);
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          OFS_CTRL: avs_readdata <= ctrl_t;
          OFS_STATUS: begin
            avs_readdata <= 32'h0000_0000;
            avs_readdata[STAT_ACTIVE_BIT] <= sdo_oe;
            avs_readdata[STAT_RDPEND_BIT] <= (rd_cnt_q != 3'd0);
            avs_readdata[STAT_FCNT_LSB +: 8] <= fcnt_q;
          end
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
      // Config is meant to change only while the port is quiet
      if (avs_write && !avs_waitrequest && avs_address == OFS_CTRL) begin
        if (avs_byteenable[0]) begin
          cfg_q.master <= avs_writedata[CTRL_MASTER_BIT];
          cfg_q.wl <= avs_writedata[CTRL_WL_LSB +: 2];
          cfg_q.append <= avs_writedata[CTRL_APPEND_BIT];
          cfg_q.diversity <= avs_writedata[CTRL_DIV_BIT];
        end
        if (avs_byteenable[1]) begin
          cfg_q.sdiv <= avs_writedata[CTRL_SDIV_LSB +: 4];
        end
      end
    end
  end
endmodule

/* fsop_port_properties.sv */
// Concurrent checks on the framed serial port pins
`timescale 1ns/1ps
module fsop_port_properties (
  input wire logic ref_clk, // Core clock
  input wire logic arst_n, // Reset, active low
  input wire logic avs_read, // Bus read
  input wire logic avs_write, // Bus write
  input wire logic avs_waitrequest, // Bus wait
  input wire fsop_pkg::fsop_cmd_s cmd_q, // Command
  input wire logic cmd_valid_q, // Command pulse
  input wire logic sclk_o, // Serial clock out
  input wire logic sclk_oe, // Clock enable
  input wire logic fs_o, // Sync out
  input wire logic fs_oe, // Sync enable
  input wire logic sdo_o, // Data out
  input wire logic sdo_oe, // Data enable
  input wire logic frame_end_o // Frame end
);
  import fsop_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Master sync holds one serial cycle, 6 to 30 core cycles
  sequence s_fs_pulse;
    fs_o [*6] ##[1:25] !fs_o;
  endsequence
  a_pin_roles: assert property ((sclk_oe == fs_oe) && (fs_oe || (!fs_o && !sclk_o)))
    else $error("pin roles inconsistent");
  a_out_on_rise: assert property (sclk_oe && sdo_oe && $past(sdo_oe) && $changed(sdo_o)
    |-> $rose(sclk_o)) else $error("data moved off the rising edge");
  a_sync_to_slot: assert property (fs_oe && $fell(fs_o) |-> $rose(sdo_oe))
    else $error("slot did not follow sync");
  a_sync_pulse: assert property (fs_oe && $rose(fs_o) |-> s_fs_pulse)
    else $error("sync pulse length wrong");
  a_clk_high: assert property (sclk_oe && $rose(sclk_o) |-> sclk_o [*3])
    else $error("serial clock high too short");
  a_clk_low: assert property (sclk_oe && $fell(sclk_o) |-> !sclk_o [*3])
    else $error("serial clock low too short");
  a_end_in_slot: assert property (frame_end_o |-> sdo_oe)
    else $error("frame end outside slot");
  a_release_after: assert property ($fell(sdo_oe) |-> $past(frame_end_o))
    else $error("data released before frame end");
  a_end_hold: assert property ($rose(frame_end_o) |-> frame_end_o [*6])
    else $error("frame end too short");
  a_cmd_flags: assert property (cmd_valid_q |-> !(cmd_q.read && cmd_q.write))
    else $error("command with both flags");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus answer late");
endmodule
bind fsop_port fsop_port_properties u_fsop_port_properties (
  .ref_clk(ref_clk), .arst_n(arst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .cmd_q(cmd_q), .cmd_valid_q(cmd_valid_q),
  .sclk_o(sclk_o), .sclk_oe(sclk_oe), .fs_o(fs_o), .fs_oe(fs_oe), .sdo_o(sdo_o),
  .sdo_oe(sdo_oe), .frame_end_o(frame_end_o)
);

/* fsop_dsp_model.sv */
// DSP-side model: slave clock and sync, serial command source
`timescale 1ns/1ps
module fsop_dsp_model (
  input wire logic go, // Rise: run one frame of clocks
  input wire logic [7:0] ncyc, // Serial cycles per frame
  input wire logic [15:0] cmd, // Command for the first word
  input wire logic sclk_w, // Resolved clock line
  input wire logic fs_w, // Resolved sync line
  output logic sclk_m, // Clock when device is slave
  output logic fs_m, // Sync when device is slave
  output logic serial_cmd_in // Command line
);
  int cnt = 99;
  logic armed = 1'b0;
  initial begin
    sclk_m = 1'b0;
    fs_m = 1'b0;
    serial_cmd_in = 1'b0;
  end
  // 25 MHz, one sync per frame, clock stands still between frames
  always @(posedge go) begin
    // Keep every edge 1 ns off the core clock edge so the port never races it
    #1;
    for (int k = 0; k < ncyc; k++) begin
      #20 sclk_m = 1'b1;
      fs_m = (k == 0);
      #20 sclk_m = 1'b0;
    end
  end
  // Sync seen on a falling edge starts the command word
  always @(negedge sclk_w) armed <= (fs_w === 1'b1);
  // Bits change on the rising edge; line held low when unused
  always @(posedge sclk_w) begin
    cnt = armed ? 0 : cnt + 1;
    serial_cmd_in <= (cnt < 16) ? cmd[15 - cnt] : 1'b0;
  end
endmodule

/* fsop_port_tb.sv */
// Self-checking bench for the framed serial output port
`timescale 1ns/1ps
module fsop_port_tb;
  import fsop_pkg::*;
  logic ref_clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00, rd_data = 8'h00, ncyc = 8'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
  logic avs_waitrequest, iq_valid = 1'b0, rd_ack = 1'b0, go = 1'b0, got = 1'b0;
  logic cmd_valid_q, sclk_o, sclk_oe, fs_o, fs_oe, sdo_o, sdo_oe, frame_end_o;
  logic sclk_m, fs_m, serial_cmd_in;
  logic [15:0] cmd_w = 16'h0000;
  logic [159:0] rx, ex;
  fsop_iq_s iq_data = '0;
  fsop_cmd_s cmd_q, last_cmd;
  int fails = 0, total_checks = 0, cyc = 0, lastr = 0, per = 0, bitc = 0, ncmd = 0, nb = 0;
  wire sclk_w = sclk_oe ? sclk_o : sclk_m;
  wire fs_w = fs_oe ? fs_o : fs_m;
  wire sdo_w = sdo_oe ? sdo_o : 1'b0; // Weak pull-down when released
  fsop_port u_fsop_port (
    .ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .iq_valid(iq_valid),
    .iq_data(iq_data), .cmd_q(cmd_q), .cmd_valid_q(cmd_valid_q), .rd_ack(rd_ack),
    .rd_data(rd_data), .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .fs_i(fs_w),
    .fs_o(fs_o), .fs_oe(fs_oe), .sdi_i(serial_cmd_in), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .frame_end_o(frame_end_o)
  );
  fsop_dsp_model u_fsop_dsp_model (
    .go(go), .ncyc(ncyc), .cmd(cmd_w), .sclk_w(sclk_w), .fs_w(fs_w), .sclk_m(sclk_m),
    .fs_m(fs_m), .serial_cmd_in(serial_cmd_in)
  );
  initial forever #2.5 ref_clk = ~ref_clk;
  // Left-justified slot word; 16-bit words keep the top of the sample
  function automatic logic [31:0] slot_word(input logic [22:0] s, input logic [1:0] wl);
    return (wl == WL_16) ? {s[22:7], 16'h0000} : {s, 9'h000};
  endfunction
  task automatic chk_vec(input logic [159:0] g, input logic [159:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t flag %b exp %b", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hold the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Watchdog: a hang counts as a mismatch
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 80000) begin
      fails++;
      report_and_stop();
    end
  end
  // Register file stand-in: answers reads, logs real accesses
  always @(posedge ref_clk) begin
    rd_ack <= cmd_valid_q && cmd_q.read;
    if (cmd_valid_q && (cmd_q.read || cmd_q.write)) begin
      last_cmd <= cmd_q;
      ncmd <= ncmd + 1;
    end
  end
  always @(posedge sclk_w) begin
    per = cyc - lastr;
    lastr = cyc;
  end
  // Capture on falling edges after a sampled sync, as the DSP does
  always @(negedge sclk_w) begin
    if (bitc == 1) chk_bit(frame_end_o, 1'b1);
    if (bitc == 2) chk_bit(frame_end_o, 1'b0);
    if (bitc > 0) begin
      rx = {rx[158:0], sdo_w};
      bitc--;
      got = (bitc == 0);
    end
    if (fs_w === 1'b1) bitc = nb;
  end
  initial begin
    logic [31:0] q, ctrl, w;
    logic [91:0] iq;
    logic [3:0] sdiv;
    logic [1:0] wl;
    logic [7:0] rb;
    logic ms, ap, dv, rd;
    int kind, ln, nw, hp, n0;
    void'($urandom(34));
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    // Every length in both modes, with and without append
    for (int t = 0; t < 12; t++) begin
      wl = 2'(t % 3);
      ms = 1'(t / 3);
      ap = 1'(t / 6);
      dv = 1'($urandom());
      sdiv = (t == 3) ? 4'h0 : (t == 4) ? 4'h2 : (t == 10) ? 4'hf : 4'($urandom());
      kind = (t < 4) ? t : $urandom_range(3, 0);
      rb = 8'($urandom());
      rd = ap || kind == 1;
      cmd_w = (kind == 0) ? 16'h0000 : {kind[0], kind[1], 3'h0, 11'($urandom())};
      rd_data <= rb;
      // Settings change only just after a reset; the first pass uses the opening reset
      if (t > 0) begin
        arst_n <= 1'b0;
        @(posedge ref_clk);
        arst_n <= 1'b1;
      end
      ctrl = {20'h0_0000, sdiv, 3'h0, dv, ap, wl, ms};
      bus(1'b1, OFS_CTRL, ctrl, q);
      bus(1'b0, OFS_CTRL, 32'h0000_0000, q);
      chk_vec(160'(q), 160'(ctrl));
      chk_bit(sclk_oe, ms);
      chk_bit(fs_oe, ms);
      iq = 92'({$urandom(), $urandom(), $urandom()});
      ln = (wl == WL_16) ? 16 : (wl == WL_24) ? 24 : 32;
      nw = (dv ? 4 : 2) + (rd ? 1 : 0);
      ex = '0;
      for (int i = 0; i < nw; i++) begin
        w = (i == 4 || (i == 2 && !dv)) ? {(kind == 1) ? rb : 8'h00, 24'h00_0000}
            : slot_word(iq[91 - 23 * i -: 23], wl);
        ex = (ex << ln) | 160'(w >> (32 - ln));
      end
      nb = ln * nw;
      ncyc <= 8'(nb + 3);
      rx = '0;
      got = 1'b0;
      n0 = ncmd;
      @(posedge ref_clk);
      iq_data <= iq;
      iq_valid <= 1'b1;
      go <= !ms;
      @(posedge ref_clk);
      iq_valid <= 1'b0;
      go <= 1'b0;
      while (!got) @(posedge ref_clk);
      chk_vec(rx, ex);
      hp = (sdiv == 4'h0) ? 1 : int'(sdiv);
      if (hp < MIN_HALF_CYC) hp = MIN_HALF_CYC;
      if (ms) chk_vec(160'(per), 160'(2 * hp));
      repeat (40) @(posedge ref_clk);
      chk_bit(sdo_oe, 1'b0);
      // No command, or both flags set: nothing reaches the register file
      if (kind == 0 || kind == 3) chk_vec(160'(ncmd - n0), 160'(0));
      else chk_vec(160'(last_cmd), 160'({cmd_w[15:14], cmd_w[10:0]}));
      bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
      chk_vec(160'(q), 160'({16'h0000, 8'h01, 6'h00, kind == 1, 1'b0}));
      bus(1'b0, 8'h08, 32'h0000_0000, q);
      chk_vec(160'(q), 160'(0));
    end
    report_and_stop();
  end
endmodule
